// [logic/ubcs_params.svh]
// constants for the user break condition sequencer
// assumes inclusion by the package and the top module
`ifndef UBCS_PARAMS_SVH
`define UBCS_PARAMS_SVH
`define UBCS_NCH          4
`define UBCS_CH_A         3'h0
`define UBCS_CH_B         3'h1
`define UBCS_CH_C         3'h2
`define UBCS_CH_D         3'h3
`define UBCS_BC_MST_CPU   7
`define UBCS_BC_MST_DMA   6
`define UBCS_BC_DAT       5
`define UBCS_BC_FET       4
`define UBCS_BC_WR        3
`define UBCS_BC_RD        2
`define UBCS_BC_SZ_HI     1
`define UBCS_BC_SZ_LO     0
`define UBCS_SZ_NONE      2'h0
`define UBCS_SZ_BYTE      2'h1
`define UBCS_SZ_WORD      2'h2
`define UBCS_SZ_LONG      2'h3
`define UBCS_IGN_LONG     32'h0000_0003
`define UBCS_IGN_WORD     32'h0000_0001
`define UBCS_IGN_BYTE     32'h0000_0000
`define UBCS_DMASK_LONG   32'hffff_ffff
`define UBCS_DMASK_LOW    32'h0000_ffff
`define UBCS_IRQ_LEVEL    4'hf
`define UBCS_STAGE_RST    2'h0
`define UBCS_CNT_RST      16'h0000
`define UBCS_PC_RST       32'h0000_0000
`endif

// [logic/ubcs_pkg.sv]
// types for the user break condition sequencer
// assumes the params header is on the include path
`include "ubcs_params.svh"
package ubcs_pkg;
    typedef enum logic [1:0] {
        SEQ_INDEP,
        SEQ_C_D,
        SEQ_B_C_D,
        SEQ_A_B_C_D
    } ubcs_seq_t;
    typedef enum logic {
        PEND_IDLE,
        PEND_WAIT
    } ubcs_pend_t;
    typedef logic [3:0][31:0] ubcs_word4_t;
    typedef logic [3:0][7:0]  ubcs_cond4_t;
endpackage

// [logic/ubcs_top.sv]
// user break channel match, sequencing and break request timing
// assumes all inputs synchronous to MCLK; INSN_VALID marks an instruction
// confirmed for execution, sampled once per instruction
`timescale 1ns/100ps
`include "ubcs_params.svh"

// Function
// - data channels need address and data match; on the main bus, data only once a size is set
// - word or byte ignores upper data halfword
// - pre-execution break saves matched instruction address
// - pre-execution defers past interrupt-inhibited slots
// - post-execution break saves following instruction address
// - post-execution defers past interrupt-inhibited instructions
// - data break lands before next accepting instruction
// - X/Y bus conditions only on C and D
// - xy enable redirects compare to X/Y bus
// - X uses upper halves, Y lower halves
// - mode 01 breaks on C then D
// - C and D together count C first
// - mode 10 breaks on B, C, D order
// - B and C together count B first
// - mode 11 breaks on A, B, C, D order
// - A and B together count A first
// - joint match with pre-exec later channel advances both
// - exec counts apply in sequence on C, D
// - request at level 15 held until accepted
// - match flags sticky, cleared only by software
// - zero master, fetch/data or read/write field disables a channel
module ubcs_top #(
    parameter int CNT_W = 16
) (
    input  wire logic                  MCLK,
    input  wire logic                  RST_B,
    input  wire logic                  INSN_VALID,
    input  wire logic [31:0]           INSN_PC,
    input  wire logic                  INSN_INT_OK,
    input  wire logic                  BUS_VALID,
    input  wire logic                  BUS_DMAC,
    input  wire logic                  BUS_WRITE,
    input  wire logic [1:0]            BUS_SIZE,
    input  wire logic [31:0]           BUS_ADDR,
    input  wire logic [31:0]           BUS_DATA,
    input  wire logic                  X_VALID,
    input  wire logic                  X_WRITE,
    input  wire logic [15:0]           X_ADDR,
    input  wire logic [15:0]           X_DATA,
    input  wire logic                  Y_VALID,
    input  wire logic                  Y_WRITE,
    input  wire logic [15:0]           Y_ADDR,
    input  wire logic [15:0]           Y_DATA,
    input  wire ubcs_pkg::ubcs_word4_t CHAN_BREAK_ADDR,
    input  wire ubcs_pkg::ubcs_word4_t CHAN_BREAK_ADDR_MASK,
    input  wire ubcs_pkg::ubcs_cond4_t CHAN_BUS_CYCLE_COND,
    input  wire logic [3:0]            PRE_POST_EXEC_SELECT,
    input  wire logic [31:0]           CHAN_C_BREAK_DATA,
    input  wire logic [31:0]           CHAN_C_BREAK_DATA_MASK,
    input  wire logic [31:0]           CHAN_D_BREAK_DATA,
    input  wire logic [31:0]           CHAN_D_BREAK_DATA_MASK,
    input  wire logic                  CHAN_C_XY_BUS_ENABLE,
    input  wire logic                  CHAN_D_XY_BUS_ENABLE,
    input  wire logic                  CHAN_C_XY_SELECT,
    input  wire logic                  CHAN_D_XY_SELECT,
    input  wire logic                  CHAN_C_EXEC_COUNT_ENABLE,
    input  wire logic                  CHAN_D_EXEC_COUNT_ENABLE,
    input  wire logic [CNT_W-1:0]      CHAN_C_EXEC_COUNT,
    input  wire logic [CNT_W-1:0]      CHAN_D_EXEC_COUNT,
    input  wire logic                  SEQUENCE_SELECT_HI,
    input  wire logic                  SEQUENCE_SELECT_LO,
    input  wire logic [3:0]            MATCH_FLAG_CLEAR,
    input  wire logic                  BRK_ACK,
    output logic [3:0]                 MATCH_FLAG,
    output logic                       BRK_REQ,
    output logic [3:0]                 BRK_LEVEL,
    output logic [31:0]                BRK_PC
);
    import ubcs_pkg::*;

    // bus cycle qualifier and masked address compare
    function automatic logic cyc_hit(
        input logic [7:0]  cond,
        input logic [31:0] baddr,
        input logic [31:0] bmask,
        input logic        is_dma,
        input logic        is_fetch,
        input logic        is_wr,
        input logic [1:0]  sz,
        input logic [31:0] addr
    );
        logic        m_ok;
        logic        f_ok;
        logic        w_ok;
        logic        s_ok;
        logic [1:0]  csz;
        logic [31:0] ign;
        csz  = cond[`UBCS_BC_SZ_HI:`UBCS_BC_SZ_LO];
        m_ok = is_dma ? cond[`UBCS_BC_MST_DMA] : cond[`UBCS_BC_MST_CPU];
        f_ok = is_fetch ? cond[`UBCS_BC_FET] : cond[`UBCS_BC_DAT];
        w_ok = is_wr ? cond[`UBCS_BC_WR] : cond[`UBCS_BC_RD];
        s_ok = (csz == `UBCS_SZ_NONE) || (csz == sz);
        case (sz)
            `UBCS_SZ_LONG: ign = `UBCS_IGN_LONG;
            `UBCS_SZ_WORD: ign = `UBCS_IGN_WORD;
            default:       ign = `UBCS_IGN_BYTE;
        endcase
        // a zero master, fetch/data or read/write field leaves its qualifier bit low
        cyc_hit = m_ok && f_ok && w_ok && s_ok &&
                  (((addr ^ baddr) & ~(bmask | ign)) == 32'h0000_0000);
    endfunction

    // data compare, active only once a size is chosen
    function automatic logic dat_hit(
        input logic [7:0]  cond,
        input logic [31:0] bdat,
        input logic [31:0] bdmask,
        input logic [31:0] dat
    );
        logic [1:0]  csz;
        logic [31:0] use_m;
        csz = cond[`UBCS_BC_SZ_HI:`UBCS_BC_SZ_LO];
        // upper halfword dropped for word and byte
        use_m = (csz == `UBCS_SZ_LONG) ? `UBCS_DMASK_LONG
                                       : `UBCS_DMASK_LOW;
        dat_hit = (csz == `UBCS_SZ_NONE) ||
                  (((dat ^ bdat) & ~bdmask & use_m) == 32'h0000_0000);
    endfunction

    // one X or Y half compare: addr, mask, data, data mask halves
    function automatic logic half_hit(
        input logic [15:0] ba,
        input logic [15:0] bam,
        input logic [15:0] bd,
        input logic [15:0] bdm,
        input logic [15:0] a,
        input logic [15:0] d
    );
        half_hit = (((a ^ ba) & ~bam) == 16'h0000) &&
                   (((d ^ bd) & ~bdm) == 16'h0000);
    endfunction

    logic [3:0]       match_flag_reg;
    logic [3:0]       match_flag_next;
    logic             brk_req_reg;
    logic             brk_req_next;
    logic [3:0]       brk_level_reg;
    logic [31:0]      brk_pc_reg;
    logic [31:0]      brk_pc_next;
    logic [1:0]       stage_reg;
    logic [1:0]       stage_next;
    ubcs_pend_t       pend_reg;
    ubcs_pend_t       pend_next;
    logic [CNT_W-1:0] cnt_c_reg;
    logic [CNT_W-1:0] cnt_c_next;
    logic [CNT_W-1:0] cnt_d_reg;
    logic [CNT_W-1:0] cnt_d_next;
    logic [3:0]       raw_hit;
    logic [3:0]       raw_pre;
    logic [3:0]       eff_hit;
    logic [3:0]       eff_pre;
    ubcs_seq_t        seq_mode;

    assign seq_mode = ubcs_seq_t'({SEQUENCE_SELECT_HI, SEQUENCE_SELECT_LO});

    // raw channel hits
    always_comb begin
        logic        xy_en;
        logic        xy_sel;
        logic        f_hit;
        logic        b_hit;
        logic        xy_hit;
        logic [31:0] bd;
        logic [31:0] bdm;
        logic [7:0]  cnd;
        xy_en  = 1'b0;
        xy_sel = 1'b0;
        f_hit  = 1'b0;
        b_hit  = 1'b0;
        xy_hit = 1'b0;
        bd     = 32'h0000_0000;
        bdm    = 32'h0000_0000;
        cnd    = 8'h00;
        raw_hit = 4'h0;
        raw_pre = 4'h0;
        for (int i = 0; i < `UBCS_NCH; i++) begin
            cnd = CHAN_BUS_CYCLE_COND[i];
            // X/Y steering exists only on C and D
            xy_en  = (i == 2) ? CHAN_C_XY_BUS_ENABLE :
                     (i == 3) ? CHAN_D_XY_BUS_ENABLE : 1'b0;
            xy_sel = (i == 2) ? CHAN_C_XY_SELECT : CHAN_D_XY_SELECT;
            bd     = (i == 2) ? CHAN_C_BREAK_DATA : CHAN_D_BREAK_DATA;
            bdm    = (i == 2) ? CHAN_C_BREAK_DATA_MASK
                              : CHAN_D_BREAK_DATA_MASK;
            f_hit = INSN_VALID && !xy_en &&
                    cyc_hit(cnd, CHAN_BREAK_ADDR[i], CHAN_BREAK_ADDR_MASK[i],
                            1'b0, 1'b1, 1'b0, `UBCS_SZ_WORD, INSN_PC);
            b_hit = BUS_VALID && !xy_en &&
                    cyc_hit(cnd, CHAN_BREAK_ADDR[i], CHAN_BREAK_ADDR_MASK[i],
                            BUS_DMAC, 1'b0, BUS_WRITE, BUS_SIZE, BUS_ADDR);
            // data qualifies only C and D
            if (i >= 2) begin
                b_hit = b_hit && dat_hit(cnd, bd, bdm, BUS_DATA);
            end
            // X/Y cycles: cpu data word, compared on one half
            if (xy_en && !xy_sel) begin
                xy_hit = X_VALID &&
                    cyc_hit(cnd, 32'h0000_0000, 32'h0000_0000, 1'b0,
                            1'b0, X_WRITE, `UBCS_SZ_WORD, 32'h0000_0000) &&
                    half_hit(CHAN_BREAK_ADDR[i][31:16],
                             CHAN_BREAK_ADDR_MASK[i][31:16],
                             bd[31:16], bdm[31:16], X_ADDR, X_DATA);
            end else if (xy_en) begin
                xy_hit = Y_VALID &&
                    cyc_hit(cnd, 32'h0000_0000, 32'h0000_0000, 1'b0,
                            1'b0, Y_WRITE, `UBCS_SZ_WORD, 32'h0000_0000) &&
                    half_hit(CHAN_BREAK_ADDR[i][15:0],
                             CHAN_BREAK_ADDR_MASK[i][15:0],
                             bd[15:0], bdm[15:0], Y_ADDR, Y_DATA);
            end else begin
                xy_hit = 1'b0;
            end
            raw_hit[i] = f_hit || b_hit || xy_hit;
            raw_pre[i] = f_hit && !PRE_POST_EXEC_SELECT[i];
        end
    end

    // execution counts on C and D
    always_comb begin
        eff_hit    = raw_hit;
        eff_pre    = raw_pre;
        cnt_c_next = cnt_c_reg;
        cnt_d_next = cnt_d_reg;
        if (CHAN_C_EXEC_COUNT_ENABLE && raw_hit[2]) begin
            if (cnt_c_reg + 1'b1 >= CHAN_C_EXEC_COUNT) begin
                cnt_c_next = `UBCS_CNT_RST;
            end else begin
                cnt_c_next = cnt_c_reg + 1'b1;
                eff_hit[2] = 1'b0;
                eff_pre[2] = 1'b0;
            end
        end
        if (CHAN_D_EXEC_COUNT_ENABLE && raw_hit[3]) begin
            if (cnt_d_reg + 1'b1 >= CHAN_D_EXEC_COUNT) begin
                cnt_d_next = `UBCS_CNT_RST;
            end else begin
                cnt_d_next = cnt_d_reg + 1'b1;
                eff_hit[3] = 1'b0;
                eff_pre[3] = 1'b0;
            end
        end
    end

    // sequencing, flags and break request
    always_comb begin
        logic [2:0] first;
        logic [2:0] e;
        logic       brk;
        logic       brk_pre;
        first   = `UBCS_CH_D;
        e       = 3'h0;
        brk     = 1'b0;
        brk_pre = 1'b0;
        stage_next = stage_reg;
        // set wins over software clear
        match_flag_next = match_flag_reg & ~MATCH_FLAG_CLEAR;
        case (seq_mode)
            SEQ_C_D:     first = `UBCS_CH_C;
            SEQ_B_C_D:   first = `UBCS_CH_B;
            SEQ_A_B_C_D: first = `UBCS_CH_A;
            default:     first = `UBCS_CH_D;
        endcase
        // channels ahead of the chain break alone
        for (int i = 0; i < `UBCS_NCH; i++) begin
            if (i < first && eff_hit[i]) begin
                match_flag_next[i] = 1'b1;
                brk                = 1'b1;
                brk_pre            = brk_pre || eff_pre[i];
            end
        end
        if (seq_mode == SEQ_INDEP) begin
            stage_next = `UBCS_STAGE_RST;
            if (eff_hit[3]) begin
                match_flag_next[3] = 1'b1;
                brk                = 1'b1;
                brk_pre            = brk_pre || eff_pre[3];
            end
        end else begin
            e = first + {1'b0, stage_reg};
            // the waiting step wins a joint match
            if (eff_hit[e[1:0]]) begin
                match_flag_next[e[1:0]] = 1'b1;
                if (e == `UBCS_CH_D) begin
                    brk        = 1'b1;
                    brk_pre    = brk_pre || eff_pre[3];
                    stage_next = `UBCS_STAGE_RST;
                end else if (eff_hit[e[1:0] + 2'h1] &&
                             eff_pre[e[1:0] + 2'h1]) begin
                    match_flag_next[e[1:0] + 2'h1] = 1'b1;
                    if (e + 3'h1 == `UBCS_CH_D) begin
                        brk        = 1'b1;
                        brk_pre    = 1'b1;
                        stage_next = `UBCS_STAGE_RST;
                    end else begin
                        stage_next = stage_reg + 2'h2;
                    end
                end else begin
                    stage_next = stage_reg + 2'h1;
                end
            end
        end
        // break timing and saved pc
        brk_req_next = brk_req_reg && !BRK_ACK;
        brk_pc_next  = brk_pc_reg;
        pend_next    = pend_reg;
        // a request already pending keeps its pc; the new hit waits
        if (brk && brk_pre && INSN_INT_OK && !brk_req_reg) begin
            // matched instruction held back, its own pc kept
            brk_req_next = 1'b1;
            brk_pc_next  = INSN_PC;
            pend_next    = PEND_IDLE;
        end else if (pend_reg == PEND_WAIT && INSN_VALID &&
                     INSN_INT_OK && !brk_req_reg) begin
            // first accepting instruction after the hit
            brk_req_next = 1'b1;
            brk_pc_next  = INSN_PC;
            pend_next    = brk ? PEND_WAIT : PEND_IDLE;
        end else if (brk) begin
            pend_next = PEND_WAIT;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            match_flag_reg <= 4'h0;
            brk_req_reg    <= 1'b0;
            brk_level_reg  <= `UBCS_IRQ_LEVEL;
            brk_pc_reg     <= `UBCS_PC_RST;
            stage_reg      <= `UBCS_STAGE_RST;
            pend_reg       <= PEND_IDLE;
            cnt_c_reg      <= `UBCS_CNT_RST;
            cnt_d_reg      <= `UBCS_CNT_RST;
        end else begin
            match_flag_reg <= match_flag_next;
            brk_req_reg    <= brk_req_next;
            brk_level_reg  <= `UBCS_IRQ_LEVEL;
            brk_pc_reg     <= brk_pc_next;
            stage_reg      <= stage_next;
            pend_reg       <= pend_next;
            cnt_c_reg      <= cnt_c_next;
            cnt_d_reg      <= cnt_d_next;
        end
    end

    assign MATCH_FLAG = match_flag_reg;
    assign BRK_REQ    = brk_req_reg;
    assign BRK_LEVEL  = brk_level_reg;
    assign BRK_PC     = brk_pc_reg;
endmodule // ubcs_top

// [testbench/ubcs_interrupt_controller_unit_model.sv]
// interrupt controller model answering the break request
// assumes the request is a level held until acknowledged
`timescale 1ns/100ps
module ubcs_interrupt_controller_unit_model (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       brk_req,
    input  wire logic [3:0] brk_level,
    input  wire logic [3:0] int_mask,
    output logic            brk_ack
);
    int wait_cnt;
    // accept only above the core mask, else hold pending
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 0;
            brk_ack  <= 1'b0;
        end else begin
            brk_ack <= 1'b0;
            if (brk_req && !brk_ack && brk_level > int_mask) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= 2) begin
                    brk_ack  <= 1'b1;
                    wait_cnt <= 0;
                end
            end
        end
    end
endmodule // ubcs_interrupt_controller_unit_model

// [testbench/ubcs_top_asserts.sv]
// port checker for the break sequencer
// assumes binding to the top module, one clock domain
`timescale 1ns/100ps
module ubcs_top_asserts #(
    parameter int CNT_W = 16
) (
    input wire logic                  MCLK,
    input wire logic                  RST_B,
    input wire logic                  INSN_VALID,
    input wire logic [31:0]           INSN_PC,
    input wire logic                  INSN_INT_OK,
    input wire ubcs_pkg::ubcs_word4_t CHAN_BREAK_ADDR,
    input wire ubcs_pkg::ubcs_word4_t CHAN_BREAK_ADDR_MASK,
    input wire ubcs_pkg::ubcs_cond4_t CHAN_BUS_CYCLE_COND,
    input wire logic [3:0]            PRE_POST_EXEC_SELECT,
    input wire logic                  SEQUENCE_SELECT_HI,
    input wire logic [3:0]            MATCH_FLAG_CLEAR,
    input wire logic                  BRK_ACK,
    input wire logic [3:0]            MATCH_FLAG,
    input wire logic                  BRK_REQ,
    input wire logic [3:0]            BRK_LEVEL,
    input wire logic [31:0]           BRK_PC
);
    import ubcs_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    a_level_fixed: assert property (BRK_LEVEL == 4'hf)
        else $error("break level not 15");
    a_req_holds: assert property (BRK_REQ && !BRK_ACK |=> BRK_REQ)
        else $error("break request dropped before ack");
    a_ack_drops: assert property (BRK_REQ && BRK_ACK |=> !BRK_REQ)
        else $error("break request kept after ack");
    a_pc_stable: assert property (BRK_REQ && !BRK_ACK |=> $stable(BRK_PC))
        else $error("saved pc moved while pending");
    a_flag_sticky: assert property ((MATCH_FLAG & ~MATCH_FLAG_CLEAR) != 4'h0
        |=> (MATCH_FLAG & $past(MATCH_FLAG & ~MATCH_FLAG_CLEAR))
        == $past(MATCH_FLAG & ~MATCH_FLAG_CLEAR))
        else $error("match flag lost without clear");
    a_off_chan: assert property (!MATCH_FLAG[0] &&
        (CHAN_BUS_CYCLE_COND[0][7:6] == 2'h0 || CHAN_BUS_CYCLE_COND[0][5:4] == 2'h0
        || CHAN_BUS_CYCLE_COND[0][3:2] == 2'h0) |=> !MATCH_FLAG[0])
        else $error("disabled channel matched");
    a_pre_fetch: assert property (INSN_VALID && INSN_INT_OK && !BRK_REQ
        && CHAN_BUS_CYCLE_COND[0] == 8'h96 && !PRE_POST_EXEC_SELECT[0]
        && !SEQUENCE_SELECT_HI && CHAN_BREAK_ADDR_MASK[0] == 32'h0
        && CHAN_BREAK_ADDR[0] == INSN_PC
        |=> BRK_REQ && MATCH_FLAG[0] && BRK_PC == $past(INSN_PC))
        else $error("pre-execution break missed");
    a_rise_cause: assert property ($rose(BRK_REQ) |->
        $past(INSN_VALID && INSN_INT_OK) && BRK_PC == $past(INSN_PC))
        else $error("break not at accepting instruction");
    c_break: cover property ($rose(BRK_REQ));
    c_all_flags: cover property (MATCH_FLAG == 4'hf);
    c_ack: cover property (BRK_REQ && BRK_ACK);
endmodule // ubcs_top_asserts
bind ubcs_top ubcs_top_asserts #(.CNT_W(CNT_W)) u_chk (
    .MCLK(MCLK),
    .RST_B(RST_B),
    .INSN_VALID(INSN_VALID),
    .INSN_PC(INSN_PC),
    .INSN_INT_OK(INSN_INT_OK),
    .CHAN_BREAK_ADDR(CHAN_BREAK_ADDR),
    .CHAN_BREAK_ADDR_MASK(CHAN_BREAK_ADDR_MASK),
    .CHAN_BUS_CYCLE_COND(CHAN_BUS_CYCLE_COND),
    .PRE_POST_EXEC_SELECT(PRE_POST_EXEC_SELECT),
    .SEQUENCE_SELECT_HI(SEQUENCE_SELECT_HI),
    .MATCH_FLAG_CLEAR(MATCH_FLAG_CLEAR),
    .BRK_ACK(BRK_ACK),
    .MATCH_FLAG(MATCH_FLAG),
    .BRK_REQ(BRK_REQ),
    .BRK_LEVEL(BRK_LEVEL),
    .BRK_PC(BRK_PC)
);

// [testbench/user_break_condition_sequencer_test.sv]
// self-checking bench for the break sequencer
// assumes the design package and the interrupt controller model
`timescale 1ns/100ps
module user_break_condition_sequencer_test;
    import ubcs_pkg::*;
    logic mclk, rst_b, iv, iok, bv, bdm, bwr, xv, xwr, yv, ywr, ack, brq;
    logic xye_c, xye_d, xys_c, xys_d, cen_c, cen_d, sq_hi, sq_lo;
    logic [1:0]  bsz;
    logic [3:0]  pp, clr, flag, lvl, imask;
    logic [15:0] xa, xd, ya, yd, cnt_c, cnt_d, h1, h2;
    logic [31:0] ipc, ba, bd, dc, dmc, dd, dmd, bpc, a0, t;
    ubcs_word4_t baddr, bmask;
    ubcs_cond4_t cond;
    int failures, checked, cyc, seed, m, n, k;
    ubcs_top DUT (.MCLK(mclk), .RST_B(rst_b), .INSN_VALID(iv), .INSN_PC(ipc),
        .INSN_INT_OK(iok), .BUS_VALID(bv), .BUS_DMAC(bdm), .BUS_WRITE(bwr),
        .BUS_SIZE(bsz), .BUS_ADDR(ba), .BUS_DATA(bd), .X_VALID(xv),
        .X_WRITE(xwr), .X_ADDR(xa), .X_DATA(xd), .Y_VALID(yv), .Y_WRITE(ywr),
        .Y_ADDR(ya), .Y_DATA(yd), .CHAN_BREAK_ADDR(baddr),
        .CHAN_BREAK_ADDR_MASK(bmask), .CHAN_BUS_CYCLE_COND(cond),
        .PRE_POST_EXEC_SELECT(pp), .CHAN_C_BREAK_DATA(dc),
        .CHAN_C_BREAK_DATA_MASK(dmc), .CHAN_D_BREAK_DATA(dd),
        .CHAN_D_BREAK_DATA_MASK(dmd), .CHAN_C_XY_BUS_ENABLE(xye_c),
        .CHAN_D_XY_BUS_ENABLE(xye_d), .CHAN_C_XY_SELECT(xys_c),
        .CHAN_D_XY_SELECT(xys_d), .CHAN_C_EXEC_COUNT_ENABLE(cen_c),
        .CHAN_D_EXEC_COUNT_ENABLE(cen_d), .CHAN_C_EXEC_COUNT(cnt_c),
        .CHAN_D_EXEC_COUNT(cnt_d), .SEQUENCE_SELECT_HI(sq_hi),
        .SEQUENCE_SELECT_LO(sq_lo), .MATCH_FLAG_CLEAR(clr), .BRK_ACK(ack),
        .MATCH_FLAG(flag), .BRK_REQ(brq), .BRK_LEVEL(lvl), .BRK_PC(bpc));
    ubcs_interrupt_controller_unit_model u_interrupt_controller_unit (.mclk(mclk), .rst_b(rst_b), .brk_req(brq),
        .brk_level(lvl), .int_mask(imask), .brk_ack(ack));
    task automatic end_of_test;
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (e !== g) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic insn(logic [31:0] pc, logic ok);
        iv = 1'b1;
        ipc = pc;
        iok = ok;
        tick(1);
        iv = 1'b0;
    endtask
    task automatic bus(logic [1:0] s, logic [31:0] a, logic [31:0] d);
        bv = 1'b1;
        bwr = 1'b1;
        bsz = s;
        ba = a;
        bd = d;
        tick(1);
        bv = 1'b0;
    endtask
    task automatic xyacc(logic y, logic [15:0] a, logic [15:0] d);
        xv = !y;
        yv = y;
        {xa, ya} = {a, a};
        {xd, yd} = {d, d};
        tick(1);
        {xv, yv} = 2'h0;
    endtask
    task automatic wait_req(logic v);
        n = 0;
        while (brq !== v && n < 40) begin
            tick(1);
            n++;
        end
        chk("brk_req", v, brq);
    endtask
    task automatic wait_brk(logic [31:0] pc);
        wait_req(1'b1);
        chk("brk_pc", pc, bpc);
        wait_req(1'b0);
    endtask
    task automatic clean;
        {cond, pp, sq_hi, sq_lo, xye_c, xye_d, xys_d, cen_c, cen_d} = '0;
        clr = 4'hf;
        tick(1);
        clr = 4'h0;
        tick(1);
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            end_of_test;
        end
    end
    initial begin
        seed = 32'hec46;
        {iv, iok, bv, bdm, bwr, xv, xwr, yv, ywr, xye_c, xye_d} = '0;
        {xys_c, xys_d, cen_c, cen_d, sq_hi, sq_lo} = '0;
        {bsz, pp, clr, imask, xa, xd, ya, yd, cnt_c, cnt_d} = '0;
        {ipc, ba, bd, dc, dmc, dd, dmd, baddr, bmask, cond} = '0;
        rst_b = 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        chk("level", 15, lvl);
        a0 = $random(seed) & 32'hffff_ff00;
        cond[0] = 8'h96;
        baddr[0] = a0;
        imask = 4'hf;
        insn(a0, 1'b1);
        tick(10);
        chk("pending", 1, brq);
        chk("flag_a", 1, flag);
        imask = 4'h0;
        wait_brk(a0);
        insn(a0, 1'b0);
        insn(a0 + 2, 1'b1);
        wait_brk(a0 + 2);
        chk("sticky", 1, flag);
        clean;
        chk("cleared", 0, flag);
        cond[1] = 8'h96;
        pp[1] = 1'b1;
        baddr[1] = a0 + 16;
        insn(a0 + 16, 1'b1);
        chk("post_wait", 0, brq);
        insn(a0 + 18, 1'b1);
        wait_brk(a0 + 18);
        insn(a0 + 16, 1'b1);
        insn(a0 + 18, 1'b0);
        insn(a0 + 20, 1'b1);
        wait_brk(a0 + 20);
        for (m = 1; m <= 3; m++) begin
            clean;
            cond[2] = (m == 2 ? 8'h68 : 8'ha8) | m[7:0];
            bdm = (m == 2);
            baddr[2] = a0 + 32;
            dc = $random(seed);
            if (m == 1) dc[15:8] = dc[7:0];
            t = dc;
            if (m < 3) t[31:16] = ~dc[31:16];
            bus(m[1:0], a0 + 32, t ^ 32'h1);
            tick(2);
            chk("data_miss", 0, flag);
            bus(m[1:0], a0 + 32, t);
            chk("data_hit", 4, flag);
            insn(a0 + 64, 1'b1);
            wait_brk(a0 + 64);
        end
        for (m = 0; m < 2; m++) begin
            clean;
            cond[2 + m] = 8'ha6;
            cond[0] = 8'ha6;
            xye_c = (m == 0);
            xye_d = (m == 1);
            xys_d = 1'b1;
            baddr[2 + m] = $random(seed);
            baddr[0] = baddr[2 + m];
            t = $random(seed);
            {dc, dd} = {t, t};
            h1 = m ? baddr[2 + m][15:0] : baddr[2 + m][31:16];
            h2 = m ? t[15:0] : t[31:16];
            xyacc(m == 0, h1, h2);
            chk("xy_other", 0, flag);
            xyacc(m == 1, h1, h2);
            chk("xy_hit", 4 << m, flag);
            insn(a0 + 64, 1'b1);
            wait_brk(a0 + 64);
        end
        for (m = 1; m <= 3; m++) begin
            clean;
            {sq_hi, sq_lo} = m[1:0];
            for (k = 3 - m; k < 4; k++) begin
                cond[k] = 8'h96;
                pp[k] = 1'b1;
                baddr[k] = a0 + 128;
            end
            repeat (m) insn(a0 + 128, 1'b1);
            chk("seq_wait", 0, brq);
            chk("seq_part", (4'hf << (3 - m)) & 4'h7, flag);
            insn(a0 + 128, 1'b1);
            insn(a0 + 130, 1'b1);
            wait_brk(a0 + 130);
            chk("seq_all", 4'hf << (3 - m) & 4'hf, flag);
        end
        clean;
        sq_lo = 1'b1;
        {cond[2], cond[3]} = {8'h96, 8'h96};
        pp[2] = 1'b1;
        {baddr[2], baddr[3]} = {a0 + 256, a0 + 256};
        insn(a0 + 256, 1'b1);
        wait_brk(a0 + 256);
        chk("joint", 4'hc, flag);
        clean;
        sq_lo = 1'b1;
        {cond[2], cond[3]} = {8'h96, 8'h96};
        {baddr[2], baddr[3]} = {a0 + 512, a0 + 544};
        {cen_c, cen_d, cnt_c, cnt_d} = {2'h3, 16'h2, 16'h3};
        insn(a0 + 512, 1'b1);
        chk("cnt_c1", 0, flag);
        insn(a0 + 512, 1'b1);
        chk("cnt_c2", 4, flag);
        repeat (2) insn(a0 + 544, 1'b1);
        chk("cnt_d2", 0, brq);
        insn(a0 + 544, 1'b1);
        wait_brk(a0 + 544);
        for (m = 0; m < 3; m++) begin
            clean;
            cond[0] = m == 0 ? 8'h16 : (m == 1 ? 8'h86 : 8'h92);
            baddr[0] = a0;
            insn(a0, 1'b1);
            tick(2);
            chk("off_chan", 0, {flag, 3'h0, brq});
        end
        end_of_test;
    end
endmodule // user_break_condition_sequencer_test
